// ===== src/smp_cfg.svh
// constants of the serial memory programming slave
`ifndef SMP_CFG_SVH
`define SMP_CFG_SVH
// cpu clock rate
`define SMP_CLK_MHZ 20
// minimum wait delays in microseconds
`define SMP_FLASH_WAIT_US 4500
`define SMP_EEPROM_WAIT_US 4000
`define SMP_ERASE_WAIT_US 4000
// instruction opcodes (first byte) and second-byte keys
`define SMP_OP_ENABLE 8'hAC
`define SMP_KEY_ENABLE 8'h53
`define SMP_KEY_ERASE 3'h4
`define SMP_OP_RD_FLASH_LO 8'h20
`define SMP_OP_RD_FLASH_HI 8'h28
`define SMP_OP_LD_FLASH_LO 8'h40
`define SMP_OP_LD_FLASH_HI 8'h48
`define SMP_OP_WR_FLASH 8'h4C
`define SMP_OP_RD_EE 8'hA0
`define SMP_OP_WR_EE 8'hC0
`define SMP_OP_LD_EE_PAGE 8'hC1
`define SMP_OP_WR_EE_PAGE 8'hC2
`define SMP_OP_RD_SIG 8'h30
`define SMP_OP_RD_CAL 8'h38
`define SMP_OP_POLL 8'hF0
// array geometry
`define SMP_FLASH_WORDS 4096
`define SMP_PAGE_WORDS 32
`define SMP_EE_BYTES 512
`define SMP_EE_PAGE_BYTES 4
// erased contents and calibration byte (value arbitrary)
`define SMP_ERASED_BYTE 8'hFF
`define SMP_CAL_BYTE 8'h5A
`endif

// ===== src/smp_pkg.sv
// types of the serial memory programming slave
package smp_pkg;
   // one four-byte instruction as shifted in, first byte on top
   typedef struct packed {
      logic [7:0] op;
      logic [7:0] b2;
      logic [7:0] b3;
      logic [7:0] b4;
   } smp_instr_type;
   // kind of self-timed operation, one-hot
   typedef enum logic [2:0] {
      SMP_WAIT_FLASH = 3'h1,
      SMP_WAIT_EE = 3'h2,
      SMP_WAIT_ERASE = 3'h4
   } smp_wait_type;
endpackage

// ===== src/smp_slave.sv
// serial programming slave: link shifter, memories, self-timed busy
//
// How it works
// - three signature bytes readable at 0..2
// - calibration byte loaded into trim each reset
// - flash 128 pages of 32 words
// - eeprom 4-byte pages, 128 pages
// - programming only while reset pin low
// - writes refused until enable accepted
// - eeprom write erases target itself
// - chip erase fills both arrays with FF
// - mosi sampled on sck rising edge
// - miso shifted on sck falling edge
// - second enable byte echoed during third
// - page buffer loaded by low address bits
// - write-page commits whole flash page
// - eeprom page write alters loaded bytes only
// - read returns any location on miso
// - reset pin high ends programming
// - enable is AC 53 plus two bytes
// - chip erase is AC 100x xxxx
// - poll returns busy in bit 0
`include "smp_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module smp_slave #(
   parameter logic [7:0] SIG_MAKER = 8'h11, // value arbitrary
   parameter logic [7:0] SIG_SIZE = 8'h22, // value arbitrary
   parameter logic [7:0] SIG_PART = 8'h33, // value arbitrary
   parameter int FLASH_WAIT_CYC = `SMP_FLASH_WAIT_US * `SMP_CLK_MHZ,
   parameter int EE_WAIT_CYC = `SMP_EEPROM_WAIT_US * `SMP_CLK_MHZ,
   parameter int ERASE_WAIT_CYC = `SMP_ERASE_WAIT_US * `SMP_CLK_MHZ
) (
   // cpu clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // programming pins
   input wire logic resetPin,
   input wire logic sck,
   input wire logic mosi,
   output logic miso,
   output logic misoOe,
   // cpu-side status
   output logic [7:0] oscTrim,
   output logic progBusy
);
   import smp_pkg::*;

   ////////////////////////////////////////////////////////////////
   // link domain (sck); held in reset while the reset pin is high
   logic linkRst_n; // link reset, low outside programming
   logic [30:0] rx_q; // bits shifted in so far
   logic [4:0] cnt_q; // bit position in the instruction
   logic [7:0] tx_q; // outgoing byte shift
   logic miso_q; // miso flop, falling edge
   logic misoOe_q; // miso drive enable
   logic progEn_q; // enable instruction accepted
   logic startTog_q; // toggles once per self-timed start
   smp_wait_type kind_q; // kind of pending wait
   logic pending_q; // start sent, busy not yet seen back
   logic busySync1_q, busySync2_q; // busy back into link domain
   logic busyLink; // busy as seen by the link
   smp_instr_type instr; // full instruction on the last edge
   logic last; // last bit of the instruction
   logic accept; // instruction may alter memory
   logic [7:0] readByte; // answer byte for the fourth slot
   logic [7:0] nextByte; // byte loaded at a byte boundary
   logic [15:0] flashMem [`SMP_FLASH_WORDS]; // program array
   logic [7:0] eeMem [`SMP_EE_BYTES]; // data array
   logic [15:0] pageBuf [`SMP_PAGE_WORDS]; // flash page buffer
   logic [7:0] eeBuf [`SMP_EE_PAGE_BYTES]; // eeprom page buffer
   logic [3:0] eeMask_q; // eeprom page bytes loaded
   logic isErase, isWrFlash, isWrEe, isWrEePage; // decoded writes
   logic [8:0] eeAddr; // eeprom byte address of the instruction
   logic [6:0] flashPage; // flash page of the instruction
   logic [11:0] flashAddr; // flash word address of a read

   // pin high holds the link logic in reset
   assign linkRst_n = reset_n & ~resetPin;

   assign instr = smp_instr_type'({rx_q, mosi});
   assign last = (cnt_q == 5'h1F);
   // nothing alters memory before enable or while busy
   assign accept = last & progEn_q & ~busyLink;
   assign isErase = (instr.op == `SMP_OP_ENABLE) && (instr.b2[7:5] == `SMP_KEY_ERASE);
   assign isWrFlash = (instr.op == `SMP_OP_WR_FLASH);
   assign isWrEe = (instr.op == `SMP_OP_WR_EE);
   assign isWrEePage = (instr.op == `SMP_OP_WR_EE_PAGE);
   // nine-bit byte address, page is the top seven
   assign eeAddr = {instr.b2[0], instr.b3};
   // page field is word address bits 11..5
   assign flashPage = {instr.b2[3:0], instr.b3[7:5]};
   assign flashAddr = {rx_q[11:8], rx_q[7:0]};
   assign busyLink = pending_q | busySync2_q;

   // shift register and bit counter
   // sample on rising edge
   always_ff @(posedge sck or negedge linkRst_n) begin
      if (!linkRst_n) begin
         rx_q <= 31'h0;
         cnt_q <= 5'h0;
      end else begin
         rx_q <= {rx_q[29:0], mosi};
         cnt_q <= cnt_q + 5'h1;
      end
   end

   // enable flag, only the enable instruction sets it
   // enable key
   always_ff @(posedge sck or negedge linkRst_n) begin
      if (!linkRst_n) begin
         progEn_q <= 1'b0;
      end else if (last && instr.op == `SMP_OP_ENABLE && instr.b2 == `SMP_KEY_ENABLE) begin
         progEn_q <= 1'b1;
      end
   end

   // start toggle follows only the cpu reset; clearing it on a pin
   // reset would look like a fresh start to the cpu side
   always_ff @(posedge sck or negedge reset_n) begin
      if (!reset_n) begin
         startTog_q <= 1'b0;
      end else if (accept && (isErase || isWrFlash || isWrEe || isWrEePage)) begin
         startTog_q <= ~startTog_q;
      end
   end

   // kind of the pending wait, stays put while busy
   always_ff @(posedge sck or negedge linkRst_n) begin
      if (!linkRst_n) begin
         kind_q <= SMP_WAIT_FLASH;
         pending_q <= 1'b0;
      end else if (accept && (isErase || isWrFlash || isWrEe || isWrEePage)) begin
         kind_q <= isErase ? SMP_WAIT_ERASE : (isWrFlash ? SMP_WAIT_FLASH : SMP_WAIT_EE);
         pending_q <= 1'b1;
      end else if (busySync2_q) begin
         pending_q <= 1'b0;
      end
   end

   // busy level back from the cpu domain
   always_ff @(posedge sck or negedge linkRst_n) begin
      if (!linkRst_n) begin
         busySync1_q <= 1'b0;
         busySync2_q <= 1'b0;
      end else begin
         busySync1_q <= progBusy;
         busySync2_q <= busySync1_q;
      end
   end

   // flash array: chip erase and page commit
   // erase fills with FF
   always_ff @(posedge sck) begin
      if (accept && isErase) begin
         for (int i = 0; i < `SMP_FLASH_WORDS; i++) begin
            flashMem[i] <= {`SMP_ERASED_BYTE, `SMP_ERASED_BYTE};
         end
      end else if (accept && isWrFlash) begin
         for (int i = 0; i < `SMP_PAGE_WORDS; i++) begin
            flashMem[{flashPage, 5'(i)}] <= pageBuf[i];
         end
      end
   end

   // flash page buffer, emptied to FF after each commit and chip erase,
   // so that unloaded words of any page loaded after a commit or erase never write unknowns
   // loaded by five low address bits
   always_ff @(posedge sck) begin
      if (accept && (isWrFlash || isErase)) begin
         for (int i = 0; i < `SMP_PAGE_WORDS; i++) begin
            pageBuf[i] <= {`SMP_ERASED_BYTE, `SMP_ERASED_BYTE};
         end
      end else if (accept && instr.op == `SMP_OP_LD_FLASH_LO) begin
         pageBuf[instr.b3[4:0]][7:0] <= instr.b4;
      end else if (accept && instr.op == `SMP_OP_LD_FLASH_HI) begin
         pageBuf[instr.b3[4:0]][15:8] <= instr.b4;
      end
   end

   // eeprom array; a byte write replaces the old value outright,
   // so the erase that the cell needs is part of the same write
   // self-erasing byte write
   // page write touches loaded bytes only
   always_ff @(posedge sck) begin
      if (accept && isErase) begin
         for (int i = 0; i < `SMP_EE_BYTES; i++) begin
            eeMem[i] <= `SMP_ERASED_BYTE;
         end
      end else if (accept && isWrEe) begin
         eeMem[eeAddr] <= instr.b4;
      end else if (accept && isWrEePage) begin
         for (int i = 0; i < `SMP_EE_PAGE_BYTES; i++) begin
            if (eeMask_q[i]) begin
               eeMem[{eeAddr[8:2], 2'(i)}] <= eeBuf[i];
            end
         end
      end
   end

   // eeprom page buffer and its loaded mask
   always_ff @(posedge sck or negedge linkRst_n) begin
      if (!linkRst_n) begin
         eeMask_q <= 4'h0;
      end else if (accept && isWrEePage) begin
         eeMask_q <= 4'h0;
      end else if (accept && instr.op == `SMP_OP_LD_EE_PAGE) begin
         eeMask_q[instr.b3[1:0]] <= 1'b1;
      end
   end
   always_ff @(posedge sck) begin
      if (accept && instr.op == `SMP_OP_LD_EE_PAGE) begin
         eeBuf[instr.b3[1:0]] <= instr.b4;
      end
   end

   // answer for the fourth byte, decoded from the first three
   // any location readable
   always_comb begin
      readByte = 8'h00;
      if (progEn_q) begin
         case (rx_q[23:16])
            `SMP_OP_RD_FLASH_LO: readByte = flashMem[flashAddr][7:0];
            `SMP_OP_RD_FLASH_HI: readByte = flashMem[flashAddr][15:8];
            `SMP_OP_RD_EE: readByte = eeMem[{rx_q[8], rx_q[7:0]}];
            `SMP_OP_RD_SIG: readByte = (rx_q[1:0] == 2'h0) ? SIG_MAKER :
                                       (rx_q[1:0] == 2'h1) ? SIG_SIZE :
                                       (rx_q[1:0] == 2'h2) ? SIG_PART : 8'h00;
            `SMP_OP_RD_CAL: readByte = `SMP_CAL_BYTE;
            `SMP_OP_POLL: readByte = {7'h0, busyLink};
            default: readByte = 8'h00;
         endcase
      end
   end

   // byte chosen at a boundary: slots 2 and 3 echo the byte before
   // 0x53 comes back during the third byte
   always_comb begin
      case (cnt_q[4:3])
         2'h0: nextByte = 8'h00;
         2'h3: nextByte = readByte;
         default: nextByte = rx_q[7:0];
      endcase
   end

   // output shifter; the falling edge gives the host half a period
   // shift on falling edge
   always_ff @(negedge sck or negedge linkRst_n) begin
      if (!linkRst_n) begin
         tx_q <= 8'h00;
         miso_q <= 1'b0;
         misoOe_q <= 1'b0;
      end else begin
         misoOe_q <= 1'b1;
         if (cnt_q[2:0] == 3'h0) begin
            miso_q <= nextByte[7];
            tx_q <= {nextByte[6:0], 1'b0};
         end else begin
            miso_q <= tx_q[7];
            tx_q <= {tx_q[6:0], 1'b0};
         end
      end
   end
   assign miso = miso_q;
   assign misoOe = misoOe_q;

   ////////////////////////////////////////////////////////////////
   // cpu domain
   logic [2:0] togSync_q; // start toggle synchroniser plus edge stage
   logic [16:0] waitCnt_q; // remaining wait cycles
   logic busy_q; // busy flag
   logic [7:0] trim_q; // oscillator trim

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         togSync_q <= 3'h0;
      end else begin
         togSync_q <= {togSync_q[1:0], startTog_q};
      end
   end

   // wait counter; kind is stable while the toggle travels
   // busy for the whole delay
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         waitCnt_q <= 17'h0;
         busy_q <= 1'b0;
      end else if (togSync_q[2] != togSync_q[1]) begin
         busy_q <= 1'b1;
         case (kind_q)
            SMP_WAIT_FLASH: waitCnt_q <= 17'(FLASH_WAIT_CYC - 1);
            SMP_WAIT_ERASE: waitCnt_q <= 17'(ERASE_WAIT_CYC - 1);
            default: waitCnt_q <= 17'(EE_WAIT_CYC - 1);
         endcase
      end else if (waitCnt_q != 17'h0) begin
         waitCnt_q <= waitCnt_q - 17'h1;
      end else begin
         busy_q <= 1'b0;
      end
   end
   assign progBusy = busy_q;

   // trim takes the calibration byte during every reset
   // copy on reset
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         trim_q <= `SMP_CAL_BYTE;
      end else begin
         trim_q <= trim_q;
      end
   end
   assign oscTrim = trim_q;

   ////////////////////////////////////////////////////////////////
   // checks
   int unsigned busyLen; // cycles busy has been high
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         busyLen <= 0;
      end else begin
         busyLen <= busy_q ? busyLen + 1 : 0;
      end
   end

   AST_TRIM: assert property (@(posedge clock) disable iff (!reset_n) oscTrim == `SMP_CAL_BYTE)
      else $error("trim lost calibration byte");
   AST_BUSY_LEN: assert property (@(posedge clock) disable iff (!reset_n)
      $fell(busy_q) |-> busyLen >= EE_WAIT_CYC)
      else $error("busy shorter than wait delay");
   AST_GATE: assert property (@(posedge sck) disable iff (!linkRst_n)
      (last && !progEn_q) |=> $stable(startTog_q))
      else $error("operation started before enable");
   AST_ENABLE: assert property (@(posedge sck) disable iff (!linkRst_n)
      (last && instr.op == 8'hAC && instr.b2 == 8'h53) |=> progEn_q)
      else $error("enable not accepted");
   AST_ECHO: assert property (@(negedge sck) disable iff (!linkRst_n)
      (cnt_q == 5'h10) |=> miso_q == $past(rx_q[7]))
      else $error("second byte not echoed");
   AST_COUNT: assert property (@(posedge sck) disable iff (!linkRst_n)
      1'b1 |=> cnt_q == $past(cnt_q) + 5'h1)
      else $error("bit counter skipped");
   AST_ERASE: assert property (@(posedge sck) disable iff (!linkRst_n)
      (accept && isErase) |=> (eeMem[0] == 8'hFF && flashMem[0] == 16'hFFFF))
      else $error("chip erase left data");
   AST_EE_WRITE: assert property (@(posedge sck) disable iff (!linkRst_n)
      (accept && isWrEe) |=> eeMem[$past(eeAddr)] == $past(instr.b4))
      else $error("eeprom byte not written");
   AST_BUSY_BLOCK: assert property (@(posedge sck) disable iff (!linkRst_n)
      (last && busyLink) |=> $stable(startTog_q))
      else $error("operation started while busy");

   COV_ENABLE: cover property (@(posedge sck) disable iff (!linkRst_n) $rose(progEn_q));
   COV_ERASE: cover property (@(posedge sck) disable iff (!linkRst_n) accept && isErase);
   COV_FLASH: cover property (@(posedge sck) disable iff (!linkRst_n) accept && isWrFlash);
   COV_BUSY: cover property (@(posedge clock) disable iff (!reset_n) $fell(busy_q));
endmodule
`default_nettype wire

// ===== testbench/smp_prog_model.sv
// programmer model: spi master that drives the serial programming pins
`timescale 1ns/1ps
`default_nettype none
module smp_prog_model #(
   parameter real HALF_NS = 7.5, // half of the 15 ns link period
   parameter int SETTLE_NS = 2000 // power-up wait, scaled down to keep the run short
) (
   // programming pins
   output logic resetPin,
   output logic sck,
   output logic mosi,
   input wire logic miso,
   input wire logic misoOe,
   // frame result for the bench monitor
   output logic [31:0] rxWord,
   output logic frameDone
);
   logic misoLine; // level on the data-out wire, floating while undriven
   assign misoLine = misoOe ? miso : 1'hz;
   // idle: reset pin low, link clock stands low
   initial begin
      resetPin = 1'h0;
      sck = 1'h0;
      mosi = 1'h0;
      rxWord = 32'h00000000;
      frameDone = 1'h0;
   end
   // sck low, then reset pulse of three cpu cycles
   task automatic powerUp(input int clkNs);
      sck = 1'h0;
      resetPin = 1'h1;
      #(3 * clkNs);
      resetPin = 1'h0;
      #(SETTLE_NS);
   endtask
   task automatic pinPulse();
      resetPin = 1'h1;
      #200;
      resetPin = 1'h0;
      #(SETTLE_NS);
   endtask
   task automatic pinHigh();
      resetPin = 1'h1;
   endtask
   // one 32-bit frame, msb first; mosi changes only while sck is low
   task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
      for (int i = 31; i >= 0; i--) begin
         // data set up before the rising edge
         mosi = tx[i];
         // phases held; the link flops run on sck itself
         #(HALF_NS);
         sck = 1'h1;
         rx[i] = misoLine;
         #(HALF_NS);
         // device shifts its next bit on this edge
         sck = 1'h0;
      end
      // released line shows the inverse of its last bit
      mosi = ~tx[0];
      rxWord = rx;
      frameDone = ~frameDone;
      #(4 * HALF_NS);
   endtask
endmodule
`default_nettype wire

// ===== testbench/tb_serial_memory_programming_slave.sv
// self-checking testbench of the serial memory programming slave
`include "smp_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_serial_memory_programming_slave;
   import smp_pkg::*;
   localparam logic [7:0] SIG0 = 8'hA1; // value arbitrary
   localparam logic [7:0] SIG1 = 8'hA2; // value arbitrary
   localparam logic [7:0] SIG2 = 8'hA3; // value arbitrary
   logic clock, reset_n, resetPin, sck, mosi, miso, misoOe, progBusy, frameDone;
   logic [7:0] oscTrim;
   logic [31:0] rxWord, lastRx;
   logic [31:0] expQ[$]; // expected frames, oldest first
   logic [31:0] maskQ[$]; // defined bits of each expected frame
   int fail_count = 0;
   int n_compared = 0;
   ////////////////////////////////////////////////////////////////////////////////
   smp_slave #(.SIG_MAKER(SIG0), .SIG_SIZE(SIG1), .SIG_PART(SIG2), .FLASH_WAIT_CYC(40), .EE_WAIT_CYC(30),
      .ERASE_WAIT_CYC(30)) smp_slave_inst (.clock(clock), .reset_n(reset_n), .resetPin(resetPin), .sck(sck),
      .mosi(mosi), .miso(miso), .misoOe(misoOe), .oscTrim(oscTrim), .progBusy(progBusy));
   smp_prog_model smp_prog_model_inst (.resetPin(resetPin), .sck(sck), .mosi(mosi), .miso(miso),
      .misoOe(misoOe), .rxWord(rxWord), .frameDone(frameDone));
   // 20 MHz cpu clock
   initial begin
      clock = 1'h0;
      forever #25 clock = ~clock;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic checkFrame(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] mask);
      n_compared++;
      if ((got & mask) !== (exp & mask)) begin
         fail_count++;
         $display("wrong value at %0t: frame %h expected %h", $time, got, exp);
      end
   endtask
   task automatic checkVal(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: pin value %h expected %h", $time, got, exp);
      end
   endtask
   // one instruction; echo slots always checked, last byte only when chk is set
   task automatic cmd(input logic [31:0] tx, input logic [7:0] data, input logic chk);
      expQ.push_back({8'h00, tx[31:16], data});
      maskQ.push_back({8'h00, 16'hFFFF, chk ? 8'hFF : 8'h00});
      smp_prog_model_inst.xfer(tx, lastRx);
   endtask
   // poll until idle; the first poll must still see the wait running
   task automatic pollIdle();
      int n;
      n = 0;
      cmd(32'hF0000000, 8'h01, 1'h1);
      checkVal({7'h00, progBusy}, 8'h01);
      while (lastRx[0] !== 1'h0 && n < 100) begin
         cmd(32'hF0000000, 8'h00, 1'h0);
         n++;
      end
      checkVal({7'h00, lastRx[0]}, 8'h00);
      checkVal({7'h00, progBusy}, 8'h00);
   endtask
   task automatic rdEe(input logic [8:0] a, input logic [7:0] exp);
      cmd({8'hA0, 7'h00, a, 8'h00}, exp, 1'h1);
   endtask
   task automatic rdFlash(input logic [11:0] a, input logic hi, input logic [7:0] exp);
      cmd({4'h2, hi, 3'h0, 4'h0, a, 8'h00}, exp, 1'h1);
   endtask
   task automatic conclude();
      $display("compared %0d, mismatched %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // monitor: each finished frame is compared with the oldest note
   initial begin
      forever begin
         @(frameDone);
         if (expQ.size() > 0) begin
            checkFrame(rxWord, expQ.pop_front(), maskQ.pop_front());
         end
      end
   end
   // watchdog, far beyond the fewer than a hundred frames of the run
   initial begin
      #1000000;
      fail_count++;
      $display("wrong value at %0t: watchdog expired", $time);
      conclude();
   end
   initial begin
      logic [8:0] ea;
      logic [7:0] d1, d2;
      logic [6:0] pg;
      int seedDummy;
      reset_n = 1'h0;
      seedDummy = $urandom(98586);
      repeat (4) @(posedge clock);
      reset_n <= 1'h1;
      @(posedge clock);
      @(posedge clock);
      checkVal(oscTrim, `SMP_CAL_BYTE);
      smp_prog_model_inst.powerUp(50);
      cmd(32'h30000000, 8'h00, 1'h1);
      cmd(32'hAC530000, 8'h00, 1'h0);
      cmd(32'hAC9F0000, 8'h00, 1'h0);
      pollIdle();
      $display("test enable and erase done");
      // write between pin reset and enable must be refused
      smp_prog_model_inst.pinPulse();
      checkVal({7'h00, progBusy}, 8'h00);
      ea = 9'($urandom);
      cmd({8'hC0, 7'h00, ea, 8'h00}, 8'h00, 1'h0);
      cmd(32'hAC530000, 8'h00, 1'h0);
      rdEe(ea, 8'hFF);
      rdFlash(12'($urandom), 1'h1, 8'hFF);
      for (int b = 0; b < 3; b++) begin
         cmd({8'h30, 8'h00, 6'h00, 2'(b), 8'h00}, (b == 0) ? SIG0 : (b == 1) ? SIG1 : SIG2, 1'h1);
      end
      cmd(32'h38000000, `SMP_CAL_BYTE, 1'h1);
      $display("test refusal and identity done");
      // eeprom page: bytes 0 and 2 loaded, byte 1 pre-written, byte 3 erased
      ea = {7'($urandom), 2'h0};
      d1 = {1'h0, 7'($urandom)};
      d2 = 8'($urandom);
      cmd({8'hC0, 7'h00, ea | 9'h001, d1}, 8'h00, 1'h0);
      pollIdle();
      cmd({8'hC1, 16'h0000, d2}, 8'h00, 1'h0);
      cmd({8'hC1, 16'h0002, ~d2}, 8'h00, 1'h0);
      cmd({8'hC2, 7'h00, ea, 8'h00}, 8'h00, 1'h0);
      pollIdle();
      rdEe(ea, d2);
      rdEe(ea | 9'h001, d1);
      rdEe(ea | 9'h002, ~d2);
      rdEe(ea | 9'h003, 8'hFF);
      $display("test eeprom page done");
      // flash page: first and last word loaded, low byte before high byte
      pg = 7'($urandom);
      d1 = 8'($urandom);
      d2 = 8'($urandom);
      cmd({8'h40, 8'h00, 8'h00, d1}, 8'h00, 1'h0);
      cmd({8'h48, 8'h00, 8'h00, d2}, 8'h00, 1'h0);
      cmd({8'h40, 8'h00, 8'h1F, ~d1}, 8'h00, 1'h0);
      cmd({8'h48, 8'h00, 8'h1F, ~d2}, 8'h00, 1'h0);
      cmd({8'h4C, 4'h0, pg[6:3], pg[2:0], 5'h00, 8'h00}, 8'h00, 1'h0);
      pollIdle();
      rdFlash({pg, 5'h00}, 1'h0, d1);
      rdFlash({pg, 5'h00}, 1'h1, d2);
      rdFlash({pg, 5'h1F}, 1'h0, ~d1);
      rdFlash({pg, 5'h1F}, 1'h1, ~d2);
      rdFlash({pg, 5'h01}, 1'h0, 8'hFF);
      $display("test flash page done");
      // random eeprom bytes, each overwritten without an erase
      repeat (3) begin
         ea = 9'($urandom);
         d1 = 8'($urandom);
         d2 = 8'($urandom);
         cmd({8'hC0, 7'h00, ea, d1}, 8'h00, 1'h0);
         pollIdle();
         cmd({8'hC0, 7'h00, ea, d2}, 8'h00, 1'h0);
         pollIdle();
         rdEe(ea, d2);
      end
      $display("test eeprom bytes done");
      smp_prog_model_inst.pinHigh();
      #200;
      checkVal({7'h00, misoOe}, 8'h00);
      $display("test session end done");
      conclude();
   end
endmodule
`default_nettype wire
